// File: rtl/lcd_mux_consts.vh
// Constants for the multiplexed LCD controller: register offsets, field positions,
// reset values, divider codes and scan timing counts.
// Assumes inclusion by bare name from the rtl files that use it.
`ifndef LCD_MUX_CONSTS_VH
`define LCD_MUX_CONSTS_VH

// Register offsets on the byte-wide register port.
`define LCD_OFS_RAM_TOP 8'h3F
`define LCD_OFS_CTRL 8'hDC
`define LCD_OFS_BANK 8'hE0
`define LCD_OFS_STATUS 8'hE1

// Field positions of the mode control register.
`define LCD_CTRL_SIXTEEN_BIT 7
`define LCD_CTRL_ELEVEN_BIT 6
`define LCD_CTRL_REF_HI 5
`define LCD_CTRL_REF_LO 3
`define LCD_CTRL_RATE_HI_BIT 1
`define LCD_CTRL_RATE_LO_BIT 0
`define LCD_CTRL_WMASK 8'hFB

// Field positions of the status register.
`define LCD_STAT_RUN_BIT 0
`define LCD_STAT_AUX_BIT 1
`define LCD_STAT_FAIL_BIT 2
`define LCD_STAT_BP_HI 7
`define LCD_STAT_BP_LO 4

// Reset values.
`define LCD_CTRL_RST 8'h00
`define LCD_BANK_RST 1'b0

// Reference divider select codes.
`define LCD_REF_OFF 3'h0
`define LCD_REF_AUX 3'h1
`define LCD_REF_DIV32 3'h3
`define LCD_REF_DIV64 3'h4
`define LCD_REF_DIV128 3'h5
`define LCD_REF_DIV256 3'h6

// Reference divider terminal counts (divide factor minus one).
`define LCD_DIV32_TC 8'h1F
`define LCD_DIV64_TC 8'h3F
`define LCD_DIV128_TC 8'h7F
`define LCD_DIV256_TC 8'hFF

// Reference tick terminal counts per backplane slot (ticks per slot minus one) for each frame rate code.
// Eight slots of the reference give the base rate, so 32768 / (8 * base).
`define LCD_SLOT_TC_256HZ 5'h0F
`define LCD_SLOT_TC_128HZ 5'h1F
`define LCD_SLOT_TC_170HZ 5'h17
`define LCD_SLOT_TC_512HZ 5'h07

// Backplane slots per frame for each ratio.
`define LCD_SLOTS_MUX8 5'h08
`define LCD_SLOTS_RATIO_ELEVEN_SELECT 5'h0B
`define LCD_SLOTS_RATIO_SIXTEEN_SELECT 5'h10

// Segment columns that are never displayed in the 1/11 and 1/16 ratios.
`define LCD_WIDE_FIRST_COL 8

`endif

// File: rtl/lcd_ref_tick_gen.v
// Reference tick generator: divides the system clock or passes the auxiliary
// oscillator tick, giving one enable pulse per reference period.
// Assumes the auxiliary tick is a one-cycle pulse synchronous to i_sys_clk.
`timescale 1ns/10ps
`include "lcd_mux_consts.vh"
module lcd_ref_tick_gen (
    // Clock and reset
    input wire i_sys_clk,
    input wire i_rst_b,
    // Control
    input wire i_run,
    input wire [2:0] i_ref_sel,
    input wire i_aux_tick,
    // Tick out
    output reg o_ref_tick
);

reg [7:0] div_cnt_q;
reg [7:0] div_tc;

always @* begin
    case (i_ref_sel)
        `LCD_REF_DIV32: div_tc = `LCD_DIV32_TC;
        `LCD_REF_DIV64: div_tc = `LCD_DIV64_TC;
        `LCD_REF_DIV128: div_tc = `LCD_DIV128_TC;
        `LCD_REF_DIV256: div_tc = `LCD_DIV256_TC;
        default: div_tc = 8'h00;
    endcase
end

always @(posedge i_sys_clk) begin
    if (!i_rst_b || !i_run) begin
        div_cnt_q <= 8'h00;
        o_ref_tick <= 1'b0;
    end else if (i_ref_sel == `LCD_REF_AUX) begin
        div_cnt_q <= 8'h00;
        o_ref_tick <= i_aux_tick;
    end else if (div_cnt_q == div_tc) begin
        div_cnt_q <= 8'h00;
        o_ref_tick <= 1'b1;
    end else begin
        div_cnt_q <= div_cnt_q + 8'h01;
        o_ref_tick <= 1'b0;
    end
end

endmodule

// File: rtl/lcd_slot_timer.v
// Backplane slot timer: counts reference ticks and marks the end of each slot.
// Assumes i_ref_tick is a one-cycle enable pulse.
`timescale 1ns/10ps
`include "lcd_mux_consts.vh"
module lcd_slot_timer (
    // Clock and reset
    input wire i_sys_clk,
    input wire i_rst_b,
    // Control
    input wire i_run,
    input wire [1:0] i_rate_sel,
    input wire i_ref_tick,
    // Slot end pulse
    output wire o_slot_end
);

reg [4:0] tick_cnt_q;
reg [4:0] slot_tc;

always @* begin
    case (i_rate_sel)
        2'b01: slot_tc = `LCD_SLOT_TC_128HZ;
        2'b10: slot_tc = `LCD_SLOT_TC_170HZ;
        2'b11: slot_tc = `LCD_SLOT_TC_512HZ;
        default: slot_tc = `LCD_SLOT_TC_256HZ;
    endcase
end

assign o_slot_end = i_run && i_ref_tick && (tick_cnt_q == slot_tc);

always @(posedge i_sys_clk) begin
    if (!i_rst_b || !i_run) begin
        tick_cnt_q <= 5'h00;
    end else if (o_slot_end) begin
        tick_cnt_q <= 5'h00;
    end else if (i_ref_tick) begin
        tick_cnt_q <= tick_cnt_q + 5'h01;
    end
end

endmodule

// File: rtl/lcd_mux_controller.v
// Multiplexed LCD controller: two-page display RAM, mode control register and the
// backplane and segment scan that drives the glass through an external bias bridge.
// Assumes all inputs synchronous to i_sys_clk and a single-cycle register port.
//
// What this block does
// - Divider select 000 gives no reference clock and blanks the display.
// - Divider codes 011, 100, 101, 110 divide the clock by 32, 64, 128, 256.
// - Oscillator failure grounds every segment and backplane output.
// - Two ratio bits select 1/8, 1/11 or 1/16; both set is reserved.
// - Frame rate codes 01, 10, 00, 11 give 128, 170, 256, 512 Hz base.
// - Frame rate is base at 1/8, half at 1/16, eight elevenths at 1/11.
// - Each RAM bit drives one dot; one is on, zero is off.
// - Display RAM is two banked 64-byte pages at addresses 00h to 3Fh.
// - At 1/8 only page one drives a 56 by 8 matrix.
// - At 1/16 both pages drive 48 by 16; bytes 00 to 07 unused.
// - At 1/11 bytes 00 to 07 and page-two bits 3 to 7 are unused.
// - Bytes 38h to 3Fh of both pages are never displayed.
// - Reset clears the control register but leaves RAM contents undefined.
// - Divider code 001 selects the auxiliary oscillator; 010 and 111 reserved.
// - Stop mode without auxiliary source grounds all lines; source changes at frame end.
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/10ps
`include "lcd_mux_consts.vh"
module lcd_mux_controller (
    // Clock and reset
    input wire i_sys_clk,
    input wire i_rst_b,
    // Register port
    input wire [7:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [7:0] o_rdata,
    // System status
    input wire i_aux_tick,
    input wire i_osc_fail,
    input wire i_stop_mode,
    // Panel drive
    output reg o_drive_en,
    output reg [15:0] o_backplane_lines,
    output reg [55:0] o_segment_columns,
    output reg o_frame_start
);

// ----------------------------------------------------------------------------
// Decoding helpers
// ----------------------------------------------------------------------------

// Number of backplane slots in one frame; zero marks the reserved ratio.
function [4:0] slots_of;
    input eleven;
    input sixteen;
    begin
        case ({sixteen, eleven})
            2'b00: slots_of = `LCD_SLOTS_MUX8;
            2'b01: slots_of = `LCD_SLOTS_RATIO_ELEVEN_SELECT;
            2'b10: slots_of = `LCD_SLOTS_RATIO_SIXTEEN_SELECT;
            default: slots_of = 5'h00;
        endcase
    end
endfunction

// A reference source that actually delivers a clock.
function src_valid;
    input [2:0] sel;
    begin
        case (sel)
            `LCD_REF_AUX: src_valid = 1'b1;
            `LCD_REF_DIV32: src_valid = 1'b1;
            `LCD_REF_DIV64: src_valid = 1'b1;
            `LCD_REF_DIV128: src_valid = 1'b1;
            `LCD_REF_DIV256: src_valid = 1'b1;
            default: src_valid = 1'b0;
        endcase
    end
endfunction

// Whether a select code routes the auxiliary oscillator instead of the divider.
function is_aux_src;
    input [2:0] sel;
    begin
        is_aux_src = (sel == `LCD_REF_AUX);
    end
endfunction

// ----------------------------------------------------------------------------
// Registers and display RAM
// ----------------------------------------------------------------------------

reg [7:0] ctrl_q;
reg bank_q;
reg [7:0] disp_ram [0:127];

wire ctrl_sixteen = ctrl_q[`LCD_CTRL_SIXTEEN_BIT];
wire ctrl_eleven = ctrl_q[`LCD_CTRL_ELEVEN_BIT];
wire [2:0] ctrl_ref_sel = ctrl_q[`LCD_CTRL_REF_HI:`LCD_CTRL_REF_LO];
wire [1:0] ctrl_rate = {ctrl_q[`LCD_CTRL_RATE_HI_BIT], ctrl_q[`LCD_CTRL_RATE_LO_BIT]};

wire ram_hit = (i_addr <= `LCD_OFS_RAM_TOP);
wire [6:0] ram_index = {bank_q, i_addr[5:0]};

wire ctrl_wr = i_wr && (i_addr == `LCD_OFS_CTRL);
wire bank_wr = i_wr && (i_addr == `LCD_OFS_BANK);
wire ram_wr = i_wr && ram_hit;

// The reserved bit 2 is masked on write so that it always reads back as zero.
always @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
        ctrl_q <= `LCD_CTRL_RST;
    end else if (ctrl_wr) begin
        ctrl_q <= i_wdata & `LCD_CTRL_WMASK;
    end
end

always @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
        bank_q <= `LCD_BANK_RST;
    end else if (bank_wr) begin
        bank_q <= i_wdata[0];
    end
end

// The RAM has no reset, so its contents after reset are whatever was there.
always @(posedge i_sys_clk) begin
    if (ram_wr) begin
        disp_ram[ram_index] <= i_wdata;
    end
end

// ----------------------------------------------------------------------------
// Scan configuration taken at frame boundaries
// ----------------------------------------------------------------------------

// The source, ratio and rate in use change only between frames while running.
reg [2:0] eff_sel_q;
reg eff_eleven_q;
reg eff_sixteen_q;
reg [1:0] eff_rate_q;
reg [3:0] bp_idx_q;
reg run_q;
reg fail_seen_q;
reg frame_end_q;

wire [4:0] eff_slots = slots_of(eff_eleven_q, eff_sixteen_q);
wire stop_kill = i_stop_mode && !is_aux_src(eff_sel_q);
wire cfg_ok = src_valid(eff_sel_q) && (eff_slots != 5'h00);
wire run_ok = cfg_ok && !i_osc_fail && !stop_kill;

wire ref_tick;
wire slot_end;
wire frame_end = slot_end && ({1'b0, bp_idx_q} == eff_slots - 5'h01);

lcd_ref_tick_gen u_ref_tick_gen (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_run(run_ok),
    .i_ref_sel(eff_sel_q),
    .i_aux_tick(i_aux_tick),
    .o_ref_tick(ref_tick)
);

lcd_slot_timer u_slot_timer (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_run(run_ok),
    .i_rate_sel(eff_rate_q),
    .i_ref_tick(ref_tick),
    .o_slot_end(slot_end)
);

always @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
        eff_sel_q <= `LCD_REF_OFF;
        eff_eleven_q <= 1'b0;
        eff_sixteen_q <= 1'b0;
        eff_rate_q <= 2'b00;
    end else if (!run_ok || frame_end) begin
        eff_sel_q <= ctrl_ref_sel;
        eff_eleven_q <= ctrl_eleven;
        eff_sixteen_q <= ctrl_sixteen;
        eff_rate_q <= ctrl_rate;
    end
end

// ----------------------------------------------------------------------------
// Backplane sequencing
// ----------------------------------------------------------------------------

always @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
        bp_idx_q <= 4'h0;
        run_q <= 1'b0;
        fail_seen_q <= 1'b0;
        frame_end_q <= 1'b0;
    end else begin
        run_q <= run_ok;
        fail_seen_q <= i_osc_fail;
        frame_end_q <= frame_end;
        if (!run_ok || frame_end) begin
            bp_idx_q <= 4'h0;
        end else if (slot_end) begin
            bp_idx_q <= bp_idx_q + 4'h1;
        end
    end
end

// ----------------------------------------------------------------------------
// Segment selection from the RAM
// ----------------------------------------------------------------------------

// Backplane index bit 3 picks the page, bits 2..0 pick the bit of each byte.
wire wide_mode = eff_eleven_q || eff_sixteen_q;
wire bp_allowed = ({1'b0, bp_idx_q} < eff_slots);
wire [55:0] seg_d;

genvar col;
generate
    for (col = 0; col < 56; col = col + 1) begin : g_col
        localparam integer COL_I = col;
        localparam [5:0] COL_ADDR = COL_I[5:0];
        wire [7:0] col_byte = disp_ram[{bp_idx_q[3], COL_ADDR}];
        wire col_shown = !(wide_mode && (col < `LCD_WIDE_FIRST_COL));
        assign seg_d[col] = col_shown && bp_allowed && col_byte[bp_idx_q[2:0]];
    end
endgenerate

// One-hot backplane selection; at 1/8 only backplanes 1..8 are ever reached.
wire [15:0] bp_d;

genvar bp;
generate
    for (bp = 0; bp < 16; bp = bp + 1) begin : g_bp
        localparam integer BP_I = bp;
        localparam [3:0] BP_IDX = BP_I[3:0];
        assign bp_d[bp] = bp_allowed && (bp_idx_q == BP_IDX);
    end
endgenerate

// ----------------------------------------------------------------------------
// Panel drive outputs
// ----------------------------------------------------------------------------

always @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
        o_drive_en <= 1'b0;
        o_backplane_lines <= 16'h0000;
        o_segment_columns <= 56'h00_0000_0000_0000;
    end else if (!run_ok) begin
        o_drive_en <= 1'b0;
        o_backplane_lines <= 16'h0000;
        o_segment_columns <= 56'h00_0000_0000_0000;
    end else begin
        o_drive_en <= 1'b1;
        o_backplane_lines <= bp_d;
        o_segment_columns <= seg_d;
    end
end

// The lines follow the backplane index one cycle late, so the frame marker is taken
// from the index as well: it rises together with the first backplane of each frame.
always @(posedge i_sys_clk) begin
    if (!i_rst_b || !run_ok) begin
        o_frame_start <= 1'b0;
    end else begin
        o_frame_start <= (bp_idx_q == 4'h0) && (!run_q || frame_end_q);
    end
end

// ----------------------------------------------------------------------------
// Register read port
// ----------------------------------------------------------------------------

reg [7:0] status_word;

always @* begin
    status_word = 8'h00;
    status_word[`LCD_STAT_RUN_BIT] = run_q;
    status_word[`LCD_STAT_AUX_BIT] = is_aux_src(eff_sel_q);
    status_word[`LCD_STAT_FAIL_BIT] = fail_seen_q;
    status_word[`LCD_STAT_BP_HI:`LCD_STAT_BP_LO] = bp_idx_q;
end

always @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
        o_rdata <= 8'h00;
    end else if (i_rd) begin
        if (ram_hit) begin
            o_rdata <= disp_ram[ram_index];
        end else begin
            case (i_addr)
                `LCD_OFS_CTRL: o_rdata <= ctrl_q;
                `LCD_OFS_BANK: o_rdata <= {7'h00, bank_q};
                `LCD_OFS_STATUS: o_rdata <= status_word;
                default: o_rdata <= 8'h00;
            endcase
        end
    end else begin
        o_rdata <= 8'h00;
    end
end

endmodule

// File: sim/lcd_mux_controller_asserts.sv
// Checker for the LCD controller: register answers and panel drive sequence.
// Assumes it is bound to lcd_mux_controller and sees only its ports.
`timescale 1ns/10ps
`include "lcd_mux_consts.vh"
module lcd_mux_controller_asserts (
    // Clock and reset
    input wire i_sys_clk,
    input wire i_rst_b,
    // Register port
    input wire [7:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    input wire [7:0] o_rdata,
    // System status
    input wire i_osc_fail,
    input wire i_stop_mode,
    // Panel drive
    input wire o_drive_en,
    input wire [15:0] o_backplane_lines,
    input wire [55:0] o_segment_columns,
    input wire o_frame_start
);
    // ----------------------------------------
    // Shadow of the mode control register
    // ----------------------------------------
    reg [7:0] ctrl_q;
    wire bad_cfg = ctrl_q[5:3] == `LCD_REF_OFF || ctrl_q[5:3] == 3'h2 || ctrl_q[5:3] == 3'h7 || ctrl_q[7:6] == 2'h3;
    always @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            ctrl_q <= 8'h00;
        end else if (i_wr && i_addr == `LCD_OFS_CTRL) begin
            ctrl_q <= i_wdata & `LCD_CTRL_WMASK;
        end
    end
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);
    property p_ctrl_read; i_rd && i_addr == `LCD_OFS_CTRL |=> o_rdata == ctrl_q; endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("control read back wrong");
    property p_rdata_idle; !i_rd |=> o_rdata == 8'h00; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not cleared");
    property p_off_stays; bad_cfg && !o_drive_en |=> !o_drive_en; endproperty
    a_off_stays: assert property (p_off_stays) else $error("scan started on a blank setting");
    property p_fail_ground; i_osc_fail |=> !o_drive_en && o_backplane_lines == 16'h0000; endproperty
    a_fail_ground: assert property (p_fail_ground) else $error("lines driven during failure");
    property p_stop_ground; i_stop_mode && ctrl_q[5:3] != `LCD_REF_AUX |=> !o_drive_en; endproperty
    a_stop_ground: assert property (p_stop_ground) else $error("lines driven in stop");
    property p_one_hot; o_drive_en |-> $onehot(o_backplane_lines); endproperty
    a_one_hot: assert property (p_one_hot) else $error("not one backplane active");
    property p_dark; !o_drive_en |-> o_backplane_lines == 16'h0000 && o_segment_columns == 56'h0; endproperty
    a_dark: assert property (p_dark) else $error("lines not grounded");
    property p_first_bp; o_frame_start |-> (o_backplane_lines == 16'h0001) ##1 !o_frame_start; endproperty
    a_first_bp: assert property (p_first_bp) else $error("frame start not on first backplane");
    property p_order;
        o_drive_en && $past(o_drive_en) && !o_frame_start && $changed(o_backplane_lines)
            |-> o_backplane_lines == $past(o_backplane_lines) << 1;
    endproperty
    a_order: assert property (p_order) else $error("backplane order broken");
    c_wide: cover property (o_frame_start && ctrl_q[7]);
    c_fail: cover property (i_osc_fail && o_drive_en);
    c_aux: cover property (o_frame_start && ctrl_q[5:3] == `LCD_REF_AUX);
endmodule
bind lcd_mux_controller lcd_mux_controller_asserts u_chk (.i_sys_clk, .i_rst_b, .i_addr, .i_wdata, .i_wr,
    .i_rd, .o_rdata, .i_osc_fail, .i_stop_mode, .o_drive_en, .o_backplane_lines, .o_segment_columns, .o_frame_start);

// File: sim/lcd_glass_model.sv
// Glass panel model: keeps the dots seen on each backplane and times slots and frames.
// Assumes panel lines settle on the system clock.
`timescale 1ns/10ps
module lcd_glass_model (
    // Clock and control
    input wire i_sys_clk,
    input wire i_clear,
    // Panel lines
    input wire i_drive_en,
    input wire [15:0] i_backplane_lines,
    input wire [55:0] i_segment_columns,
    input wire i_frame_start,
    // Observations
    output logic [15:0] o_seen = 16'h0000,
    output int o_slot_len = 0,
    output int o_frame_len = 0
);
    logic [55:0] dot [16];
    logic [15:0] last_bp = 16'h0000;
    int slot_cnt = 0;
    int frame_cnt = 0;
    always @(posedge i_sys_clk) begin
        slot_cnt <= slot_cnt + 1;
        frame_cnt <= frame_cnt + 1;
        last_bp <= i_backplane_lines;
        if (i_backplane_lines != last_bp) begin
            o_slot_len <= slot_cnt;
            slot_cnt <= 1;
        end
        if (i_frame_start) begin
            o_frame_len <= frame_cnt;
            frame_cnt <= 1;
        end
        o_seen <= i_clear ? 16'h0000 : o_seen | i_backplane_lines;
        for (int b = 0; b < 16; b++)
            if (i_drive_en && i_backplane_lines[b]) dot[b] <= i_segment_columns;
    end
endmodule

// File: sim/lcd_mux_controller_bench.sv
// Self-checking bench for the LCD controller: register port, display RAM and panel scan.
// Assumes the glass model and the bound checker are compiled alongside.
`timescale 1ns/10ps
module lcd_mux_controller_bench;
    logic i_sys_clk = 0;
    logic i_rst_b = 0;
    logic [7:0] i_addr = 8'h00;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 0;
    logic i_rd = 0;
    logic i_aux_tick = 0;
    logic i_osc_fail = 0;
    logic i_stop_mode = 0;
    logic i_clear = 0;
    wire [7:0] o_rdata;
    wire o_drive_en;
    wire [15:0] o_backplane_lines;
    wire [55:0] o_segment_columns;
    wire o_frame_start;
    wire [15:0] seen;
    int slot_len;
    int frame_len;
    int mismatches = 0;
    int comparisons = 0;
    int aux_gap = 0;
    logic [31:0] rng = 32'h0000_8044;
    logic [7:0] mem [2][64];
    logic [7:0] d;
    // Every divider setting here keeps the reference well above the low limit.
    logic [7:0] ctl [6] = '{8'h23, 8'h2B, 8'h33, 8'h18, 8'h19, 8'h1A};
    int len [6] = '{512, 1024, 2048, 512, 1024, 768};
    logic [7:0] bad [4] = '{8'hDB, 8'h03, 8'h13, 8'h3B};
    lcd_mux_controller DUT (.i_sys_clk, .i_rst_b, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_aux_tick,
        .i_osc_fail, .i_stop_mode, .o_drive_en, .o_backplane_lines, .o_segment_columns, .o_frame_start);
    lcd_glass_model glass (.i_sys_clk, .i_clear, .i_drive_en(o_drive_en), .i_backplane_lines(o_backplane_lines),
        .i_segment_columns(o_segment_columns), .i_frame_start(o_frame_start), .o_seen(seen),
        .o_slot_len(slot_len), .o_frame_len(frame_len));
    always #5 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk) i_aux_tick <= aux_gap != 0 && $time / 10 % aux_gap == 0;
    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction
    function automatic logic exp_dot(logic [7:0] ctrl, int bp, int col);
        if (ctrl[7:6] != 2'h0 && col < 8) return 1'b0;
        return mem[bp / 8][col][bp % 8];
    endfunction
    task automatic check(logic [63:0] got, logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] v);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_wdata <= v;
        i_wr <= 1'b1;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1 check(o_rdata, e);
    endtask
    task automatic frames(int n);
        repeat (n) begin
            @(negedge i_sys_clk);
            for (int i = 0; i < 40000 && o_frame_start !== 1'b1; i++) @(negedge i_sys_clk);
        end
    endtask
    task automatic scan(logic [7:0] ctrl, int nbp, int slot, logic [15:0] seen_exp);
        int first;
        // A scan started from idle, or one on the free-running auxiliary tick, has a first
        // frame of uneven length, so the second frame is the one measured then.
        first = (o_drive_en === 1'b1 && ctrl[5:3] != 3'h1) ? 1 : 2;
        wr(8'hDC, ctrl);
        frames(first);
        @(posedge i_sys_clk) i_clear <= 1'b1;
        @(posedge i_sys_clk) i_clear <= 1'b0;
        frames(1);
        @(posedge i_sys_clk);
        #1 check(frame_len, nbp * slot);
        check(slot_len, slot);
        check(seen, seen_exp);
        for (int b = 0; b < nbp; b++)
            for (int c = 0; c < 56; c++)
                check(glass.dot[b][c], exp_dot(ctrl, b, c));
    endtask
    task automatic pulse_check(logic stop);
        @(posedge i_sys_clk) {i_stop_mode, i_osc_fail} <= {stop, !stop};
        repeat (2) @(posedge i_sys_clk);
        #1 check({o_drive_en, o_backplane_lines}, 17'h0_0000);
        @(posedge i_sys_clk) {i_stop_mode, i_osc_fail} <= 2'b00;
    endtask
    // ----------------------------------------
    // Stimulus and checks
    // ----------------------------------------
    initial begin
        #(100000 * 10);
        mismatches++;
        finish_test();
    end
    initial begin
        repeat (16) @(posedge i_sys_clk);
        i_rst_b <= 1'b1;
        #1 check(o_drive_en, 1'b0);
        rd(8'hDC, 8'h00);
        rd(8'h40, 8'h00);
        repeat (6) begin
            d = 8'(xs()) & 8'hC7;
            wr(8'hDC, d);
            rd(8'hDC, d & 8'hFB);
            check(o_drive_en, 1'b0);
        end
        for (int p = 0; p < 2; p++) begin
            wr(8'hE0, p[7:0]);
            for (int a = 0; a < 64; a++) begin
                mem[p][a] = 8'(xs());
                wr(a[7:0], mem[p][a]);
                rd(a[7:0], mem[p][a]);
            end
        end
        wr(8'hE0, 8'h00);
        rd(8'h05, mem[0][5]);
        scan(8'h1B, 8, 256, 16'h00FF);
        scan(8'h9B, 16, 256, 16'hFFFF);
        scan(8'h5B, 11, 256, 16'h07FF);
        foreach (ctl[i]) begin
            wr(8'hDC, ctl[i]);
            frames(1);
            @(o_backplane_lines);
            repeat (2) @(posedge i_sys_clk);
            #1 check(slot_len, len[i]);
        end
        aux_gap = 6 + xs() % 4;
        scan(8'h0B, 8, 8 * aux_gap, 16'h00FF);
        @(posedge i_sys_clk) i_stop_mode <= 1'b1;
        frames(1);
        check(o_drive_en, 1'b1);
        @(posedge i_sys_clk) i_stop_mode <= 1'b0;
        wr(8'hDC, 8'h1B);
        frames(2);
        pulse_check(1'b1);
        frames(1);
        pulse_check(1'b0);
        foreach (bad[i]) begin
            wr(8'hDC, 8'h1B);
            wr(8'hDC, bad[i]);
            repeat (2100) @(posedge i_sys_clk);
            #1 check(o_drive_en, 1'b0);
        end
        finish_test();
    end
endmodule
